// ===== serial_port_regs.vh
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH
// ****************************************
// register byte addresses
// ****************************************
`define ADDR_SERIAL_CONTROL 4'h0
`define ADDR_SERIAL_BUFFER  4'h4
`define ADDR_POWER_CONTROL  4'h8
// ****************************************
// serial control field positions
// ****************************************
`define SC_RX_DONE    0
`define SC_TX_DONE    1
`define SC_RX_NINTH   2
`define SC_TX_NINTH   3
`define SC_RX_ENABLE  4
`define SC_MULTIPROC  5
`define SC_MODE_LO    6
`define SC_MODE_HI_FE 7
// ****************************************
// power control field positions
// ****************************************
`define PC_FE_VIEW    6
`define PC_BAUD_DBL   7
// ****************************************
// reset values and timing counts
// ****************************************
`define SERIAL_CONTROL_RESET 8'h00
`define POWER_CONTROL_RESET  8'h00
`define SLICES_PER_BIT       4'hF
`define SAMPLE_FIRST         4'h7
`define SAMPLE_SECOND        4'h8
`define SAMPLE_LAST          4'h9
`define MODE0_SLOW_DIV       4'hC
`define MODE0_FAST_DIV       4'h4
`define OSC_SLICE_DIV        4'h2
`endif

// ===== majority_vote.v
`timescale 1ns/100ps
// ****************************************
// two of three vote
// ****************************************
module majority_vote (
  input  wire [2:0] samples,
  output wire       bit_value
);
  assign bit_value = (samples[0] & samples[1]) | (samples[0] & samples[2]) |
                     (samples[1] & samples[2]);
endmodule // majority_vote

// ===== serial_port_async.v
`timescale 1ns/100ps
`include "serial_port_regs.vh"
module serial_port_async (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire        clk_en,
  input  wire        timer1_overflow,
  input  wire        serial_in,
  output reg         serial_out,
  output reg         shift_clk_out,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  // ****************************************
  // registers
  // ****************************************
  reg [7:0] serial_control_reg;
  reg       frame_error_flag;
  reg [7:0] power_control_reg;
  reg [7:0] serial_buffer;
  reg [7:0] tx_shift;
  reg [3:0] aw_addr;
  reg       aw_held;
  reg [31:0] w_data;
  reg       w_held;
  reg [1:0] rx_sync;
  reg       rx_prev;
  reg       timer_half;
  reg [5:0] osc_div;
  wire mode_hi  = serial_control_reg[`SC_MODE_HI_FE];
  wire mode_lo  = serial_control_reg[`SC_MODE_LO];
  wire mode0    = ~mode_hi & ~mode_lo;
  wire nine_bit = mode_hi;
  wire mode2    =  mode_hi & ~mode_lo;
  wire rx_pin   = rx_sync[1];
  // ****************************************
  // bus write path
  // ****************************************
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire wr_buf   = do_write & (aw_addr == `ADDR_SERIAL_BUFFER) & w_data[0];
  wire wr_ctl   = do_write & (aw_addr == `ADDR_SERIAL_CONTROL);
  wire wr_pwr   = do_write & (aw_addr == `ADDR_POWER_CONTROL);
  wire wr_mapped = wr_ctl | wr_pwr | (aw_addr == `ADDR_SERIAL_BUFFER);
  // ****************************************
  // slice tick: 16 per bit
  // ****************************************
  // mode 2 slice = osc/2 (x16=32) or osc/4 (x16=64)
  reg slice_tick;
  always @* begin
    if (mode2) begin
      if (power_control_reg[`PC_BAUD_DBL])
        slice_tick = (osc_div[0] == 1'b1);
      else
        slice_tick = (osc_div[1:0] == 2'b11);
    end else if (power_control_reg[`PC_BAUD_DBL]) begin
      slice_tick = timer1_overflow;
    end else begin
      slice_tick = timer1_overflow & timer_half;
    end
  end
  always @(posedge ref_clk) begin
    if (reset) begin
      osc_div    <= 6'h00;
      timer_half <= 1'b0;
      rx_sync    <= 2'b11;
      rx_prev    <= 1'b1;
    end else if (clk_en) begin
      osc_div <= osc_div + 6'h01;
      if (timer1_overflow)
        timer_half <= ~timer_half;
      rx_sync <= {rx_sync[0], serial_in};
      rx_prev <= rx_pin;
    end
  end
  // ****************************************
  // transmitter
  // ****************************************
  // free running counter: first bit waits for its rollover, not the write
  reg [3:0] tx_slice;
  reg [3:0] tx_count;
  reg       tx_busy;
  reg       tx_ninth;
  reg       tx_done_set;
  wire      tx_roll = slice_tick & (tx_slice == `SLICES_PER_BIT);
  wire [3:0] tx_last = nine_bit ? 4'hB : 4'hA;
  always @(posedge ref_clk) begin
    if (reset) begin
      tx_slice    <= 4'h0;
      tx_count    <= 4'h0;
      tx_busy     <= 1'b0;
      tx_shift    <= 8'hFF;
      tx_ninth    <= 1'b1;
      serial_out  <= 1'b1;
      tx_done_set <= 1'b0;
    end else if (clk_en) begin
      tx_done_set <= 1'b0;
      if (slice_tick)
        tx_slice <= tx_slice + 4'h1;
      if (wr_buf & ~mode0) begin
        tx_busy  <= 1'b1;
        tx_count <= 4'h0;
        tx_shift <= w_data[15:8];
        tx_ninth <= serial_control_reg[`SC_TX_NINTH];
      end else if (tx_busy & tx_roll) begin
        tx_count <= tx_count + 4'h1;
        if (tx_count == 4'h0) begin
          serial_out <= 1'b0;
        end else if (tx_count <= 4'h8) begin
          serial_out <= tx_shift[0];
          tx_shift   <= {1'b1, tx_shift[7:1]};
        end else if (tx_count == 4'h9 & nine_bit) begin
          serial_out <= tx_ninth;
        end else begin
          serial_out <= 1'b1;
        end
        // flag rises with the stop bit; a new write still waits for a rollover
        if (tx_count == tx_last - 4'h1) begin
          tx_busy     <= 1'b0;
          tx_done_set <= 1'b1;
        end
      end
    end
  end
  // ****************************************
  // receiver
  // ****************************************
  localparam RX_HUNT = 2'b00;
  localparam RX_BITS = 2'b01;
  localparam RX_M0   = 2'b10;
  reg [1:0] rx_state;
  reg [3:0] rx_slice;
  reg [3:0] rx_count;
  reg [2:0] rx_samples;
  reg [8:0] rx_shift;
  reg [3:0] m0_div;
  reg       rx_load;
  reg       rx_fe_set;
  reg [7:0] rx_byte;
  reg       rx_ninth;
  wire      voted;
  majority_vote vote_u (
    .samples   (rx_samples),
    .bit_value (voted)
  );
  wire [3:0] rx_last = nine_bit ? 4'hA : 4'h9;
  wire [3:0] m0_top = serial_control_reg[`SC_MULTIPROC] ?
                      `MODE0_FAST_DIV - 4'h1 : `MODE0_SLOW_DIV - 4'h1;
  always @(posedge ref_clk) begin
    if (reset) begin
      rx_state      <= RX_HUNT;
      rx_slice      <= 4'h0;
      rx_count      <= 4'h0;
      rx_samples    <= 3'b000;
      rx_shift      <= 9'h000;
      m0_div        <= 4'h0;
      rx_load       <= 1'b0;
      rx_fe_set     <= 1'b0;
      rx_byte       <= 8'h00;
      rx_ninth      <= 1'b0;
      shift_clk_out <= 1'b1;
    end else if (clk_en) begin
      rx_load   <= 1'b0;
      rx_fe_set <= 1'b0;
      case (rx_state)
        RX_HUNT: begin
          shift_clk_out <= 1'b1;
          if (mode0) begin
            // done flag lands a cycle after the load pulse; do not restart meanwhile
            if (serial_control_reg[`SC_RX_ENABLE] & ~serial_control_reg[`SC_RX_DONE] &
                ~rx_load) begin
              rx_state <= RX_M0;
              rx_count <= 4'h0;
              m0_div   <= 4'h0;
            end
          end else if (serial_control_reg[`SC_RX_ENABLE] & rx_prev & ~rx_pin) begin
            rx_state <= RX_BITS;
            rx_slice <= 4'h0;
            rx_count <= 4'h0;
          end
        end
        RX_BITS: begin
          if (slice_tick) begin
            rx_slice <= rx_slice + 4'h1;
            if (rx_slice == `SAMPLE_FIRST)
              rx_samples[0] <= rx_pin;
            if (rx_slice == `SAMPLE_SECOND)
              rx_samples[1] <= rx_pin;
            if (rx_slice == `SAMPLE_LAST)
              rx_samples[2] <= rx_pin;
            if (rx_slice == `SAMPLE_LAST + 4'h1) begin
              rx_count <= rx_count + 4'h1;
              if (rx_count == 4'h0) begin
                if (voted)
                  rx_state <= RX_HUNT;
              end else if (rx_count == rx_last) begin
                // stop bit is voted, not shifted; decide at mid stop
                rx_state <= RX_HUNT;
                rx_byte  <= nine_bit ? rx_shift[8:1] : rx_shift[8:1];
                rx_ninth <= nine_bit ? rx_shift[8] : voted;
                if (nine_bit)
                  rx_byte <= rx_shift[7:0];
                if (~serial_control_reg[`SC_RX_DONE] &
                    (~serial_control_reg[`SC_MULTIPROC] | voted))
                  rx_load <= 1'b1;
                if (~voted)
                  rx_fe_set <= 1'b1;
              end else begin
                rx_shift <= {voted, rx_shift[8:1]};
              end
            end
          end
        end
        RX_M0: begin
          m0_div <= (m0_div == m0_top) ? 4'h0 : m0_div + 4'h1;
          if (m0_div == 4'h0)
            shift_clk_out <= 1'b0;
          if (m0_div == (m0_top >> 1) + 4'h1) begin
            shift_clk_out <= 1'b1;
            rx_shift <= {rx_pin, rx_shift[8:1]};
            rx_count <= rx_count + 4'h1;
            if (rx_count == 4'h7) begin
              rx_state <= RX_HUNT;
              rx_byte  <= {rx_pin, rx_shift[8:2]};
              rx_ninth <= serial_control_reg[`SC_RX_NINTH];
              rx_load  <= 1'b1;
            end
          end
        end
        default: rx_state <= RX_HUNT;
      endcase
    end
  end
  // ****************************************
  // control, status and bus slave
  // ****************************************
  // hardware set wins over a software clear in the same cycle
  wire fe_view = power_control_reg[`PC_FE_VIEW];
  always @(posedge ref_clk) begin
    if (reset) begin
      serial_control_reg <= `SERIAL_CONTROL_RESET;
      power_control_reg  <= `POWER_CONTROL_RESET;
      frame_error_flag   <= 1'b0;
      serial_buffer      <= 8'h00;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h00000000;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'b00;
      s_axi_rdata   <= 32'h00000000;
    end else if (clk_en) begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= {16'h0000, s_axi_wdata[7:0], {7'h00, s_axi_wstrb[0]}};
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_ctl & w_data[0]) begin
        serial_control_reg[6:0] <= w_data[14:8];
        if (fe_view)
          frame_error_flag <= w_data[15];
        else
          serial_control_reg[`SC_MODE_HI_FE] <= w_data[15];
      end
      if (wr_pwr & w_data[0])
        power_control_reg <= w_data[15:8];
      if (tx_done_set)
        serial_control_reg[`SC_TX_DONE] <= 1'b1;
      if (rx_load) begin
        serial_buffer <= rx_byte;
        serial_control_reg[`SC_RX_NINTH] <= rx_ninth;
        serial_control_reg[`SC_RX_DONE]  <= 1'b1;
      end
      if (rx_fe_set)
        frame_error_flag <= 1'b1;
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr)
          `ADDR_SERIAL_CONTROL:
            s_axi_rdata <= {24'h000000, fe_view ? frame_error_flag : mode_hi,
                            serial_control_reg[6:0]};
          `ADDR_SERIAL_BUFFER: s_axi_rdata <= {24'h000000, serial_buffer};
          `ADDR_POWER_CONTROL: s_axi_rdata <= {24'h000000, power_control_reg};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // serial_port_async

// ===== serial_port_async_monitor.sv
`timescale 1ns/100ps
// ****************************************
// port checker
// ****************************************
module serial_port_async_monitor (
  input wire        ref_clk,
  input wire        reset,
  input wire        clk_en,
  input wire        serial_out,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  sequence s_wr_take;
    s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_tx_edge;
    $changed(serial_out);
  endsequence
  a_tx_idle_high:
  assert property ($fell(reset) |-> serial_out) else $error("line not idle high");
  // a bit is 16 slices of at least one clock, so no edge follows another soon
  a_tx_bit_hold:
  assert property (s_tx_edge |=> $stable(serial_out)[*8]) else $error("tx bit too short");
  a_freeze_hold:
  assert property (!clk_en |=> $stable(serial_out) && $stable(s_axi_bvalid))
    else $error("state moved while frozen");
  a_write_answer:
  assert property (s_wr_take |-> ##[1:4] s_axi_bvalid) else $error("no write answer");
  a_read_answer:
  assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  a_ready_pulse:
  assert property (s_axi_arready |=> !s_axi_arready) else $error("arready not a pulse");
  a_rdata_upper:
  assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_slverr_zero:
  assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h00000000)
    else $error("error read not zero");
endmodule // serial_port_async_monitor
bind serial_port_async serial_port_async_monitor mon_u (
  .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .serial_out(serial_out),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

// ===== serial_far_end.sv
`timescale 1ns/100ps
// ****************************************
// remote serial device
// ****************************************
module serial_far_end (
  input  wire ref_clk,
  input  wire serial_out,
  output reg  serial_in
);
  initial serial_in = 1'b1;
  // bits[0] is the start bit; line returns high after the frame
  task send(input [10:0] bits, input integer n, input integer per);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        serial_in <= bits[i];
        repeat (per) @(posedge ref_clk);
      end
      serial_in <= 1'b1;
    end
  endtask
  // mid-bit sampling tolerates small phase offsets
  task capture(output [10:0] bits, input integer n, input integer per);
    integer i;
    begin
      bits = 11'h7FF;
      @(negedge serial_out);
      repeat (per / 2) @(posedge ref_clk);
      for (i = 0; i < n; i = i + 1) begin
        bits[i] = serial_out;
        repeat (per) @(posedge ref_clk);
      end
    end
  endtask
endmodule // serial_far_end

// ===== serial_port_async_tb.sv
`timescale 1ns/100ps
`include "serial_port_regs.vh"
module serial_port_async_tb;
  reg         ref_clk, reset, clk_en, t1_ovf;
  reg  [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg  [31:0] s_axi_wdata, rd;
  reg  [1:0]  rs, bs;
  reg  [10:0] cap;
  wire        sin, sout, sclk, awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  integer     error_cnt = 0;
  integer     num_checks = 0;
  integer     sclk_falls = 0;
  serial_port_async dut_u (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .timer1_overflow(t1_ovf),
    .serial_in(sin), .serial_out(sout), .shift_clk_out(sclk),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(s_axi_rready));
  serial_far_end far_u (.ref_clk(ref_clk), .serial_out(sout), .serial_in(sin));
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end
  // overflow every second clock, so timer/16 gives a 32 clock bit
  always @(posedge ref_clk) t1_ovf <= ~t1_ovf;
  always @(negedge sclk) sclk_falls = sclk_falls + 1;
  // ****************************************
  // bus tasks
  // ****************************************
  task check(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task axi_wr(input [3:0] a, input [7:0] d);
    reg done;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      done = 0;
      while (!done) begin
        @(posedge ref_clk);
        if (awready) s_axi_awvalid <= 1'b0;
        if (wready) s_axi_wvalid <= 1'b0;
        bs = bresp;
        if (bvalid) done = 1;
      end
    end
  endtask
  task axi_rd(input [3:0] a);
    reg done;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      done = 0;
      while (!done) begin
        @(posedge ref_clk);
        if (arready) s_axi_arvalid <= 1'b0;
        rd = rdata;
        rs = rresp;
        if (rvalid) done = 1;
      end
    end
  endtask
  task rd_chk(input [3:0] a, input [7:0] exp);
    begin
      axi_rd(a);
      check(rd, {24'h000000, exp});
    end
  endtask
  task tally_and_finish;
    begin
      if (error_cnt == 0 && num_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    repeat (30000) @(posedge ref_clk);
    error_cnt = error_cnt + 1;
    tally_and_finish;
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    {reset, clk_en, t1_ovf, s_axi_bready, s_axi_rready} = 5'b11011;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 12'h00F;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_wdata} = 35'h0;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    clk_en <= 1'b0;
    repeat (3) @(posedge ref_clk);
    clk_en <= 1'b1;
    rd_chk(`ADDR_SERIAL_CONTROL, 8'h00);
    rd_chk(`ADDR_POWER_CONTROL, 8'h00);
    axi_rd(4'hC);
    check(rd, 32'h00000000);
    check({30'h0, rs}, 32'h00000002);
    axi_wr(4'hC, 8'hFF);
    check({30'h0, bs}, 32'h00000002);
    axi_wr(`ADDR_POWER_CONTROL, 8'h80);
    check({30'h0, bs}, 32'h00000000);
    axi_wr(`ADDR_SERIAL_CONTROL, 8'h88);
    fork
      far_u.capture(cap, 11, 32);
      axi_wr(`ADDR_SERIAL_BUFFER, 8'hA5);
    join
    check({21'h0, cap}, {21'h0, 2'b11, 8'hA5, 1'b0});
    rd_chk(`ADDR_SERIAL_CONTROL, 8'h8A);
    axi_wr(`ADDR_SERIAL_CONTROL, 8'h50);
    fork
      far_u.capture(cap, 10, 32);
      begin
        axi_wr(`ADDR_SERIAL_BUFFER, 8'h5A);
        @(negedge sout);
        repeat (296) @(posedge ref_clk);
        rd_chk(`ADDR_SERIAL_CONTROL, 8'h52);
      end
    join
    check({21'h0, cap}, {21'h0, 2'b11, 8'h5A, 1'b0});
    far_u.send({2'b11, 8'h96, 1'b0}, 10, 32);
    rd_chk(`ADDR_SERIAL_CONTROL, 8'h57);
    rd_chk(`ADDR_SERIAL_BUFFER, 8'h96);
    axi_wr(`ADDR_SERIAL_CONTROL, 8'h50);
    far_u.send(11'h000, 1, 4);
    repeat (400) @(posedge ref_clk);
    rd_chk(`ADDR_SERIAL_CONTROL, 8'h50);
    axi_wr(`ADDR_SERIAL_CONTROL, 8'hC0);
    fork
      far_u.capture(cap, 11, 32);
      axi_wr(`ADDR_SERIAL_BUFFER, 8'h0F);
    join
    check({21'h0, cap}, {21'h0, 2'b10, 8'h0F, 1'b0});
    axi_wr(`ADDR_POWER_CONTROL, 8'h00);
    axi_wr(`ADDR_SERIAL_CONTROL, 8'h90);
    far_u.send({2'b11, 8'h3C, 1'b0}, 11, 64);
    rd_chk(`ADDR_SERIAL_CONTROL, 8'h95);
    far_u.send({2'b10, 8'h55, 1'b0}, 11, 64);
    rd_chk(`ADDR_SERIAL_CONTROL, 8'h95);
    rd_chk(`ADDR_SERIAL_BUFFER, 8'h3C);
    axi_wr(`ADDR_SERIAL_CONTROL, 8'hB0);
    far_u.send({2'b01, 8'h66, 1'b0}, 11, 64);
    axi_wr(`ADDR_POWER_CONTROL, 8'h40);
    rd_chk(`ADDR_SERIAL_CONTROL, 8'hB0);
    rd_chk(`ADDR_SERIAL_BUFFER, 8'h3C);
    axi_wr(`ADDR_POWER_CONTROL, 8'h00);
    axi_wr(`ADDR_SERIAL_CONTROL, 8'hB0);
    far_u.send({2'b10, 8'h21, 1'b0}, 11, 64);
    axi_wr(`ADDR_POWER_CONTROL, 8'h40);
    rd_chk(`ADDR_SERIAL_CONTROL, 8'hB1);
    rd_chk(`ADDR_SERIAL_BUFFER, 8'h21);
    axi_wr(`ADDR_SERIAL_CONTROL, 8'h10);
    rd_chk(`ADDR_SERIAL_CONTROL, 8'h10);
    axi_wr(`ADDR_POWER_CONTROL, 8'h00);
    rd_chk(`ADDR_SERIAL_CONTROL, 8'h90);
    axi_wr(`ADDR_SERIAL_CONTROL, 8'h30);
    repeat (60) @(posedge ref_clk);
    rd_chk(`ADDR_SERIAL_CONTROL, 8'h31);
    rd_chk(`ADDR_SERIAL_BUFFER, 8'hFF);
    check(sclk_falls, 32'h00000008);
    tally_and_finish;
  end
endmodule // serial_port_async_tb
